// [inc/sar_pkg.sv]
// Shared constants and types for the successive approximation register
package sar_pkg;
    localparam int RESULT_W = 8;
    localparam logic [2:0] MSB_IDX = 3'h7;
    localparam logic [2:0] LSB_IDX = 3'h0;
    localparam logic [2:0] CASCADE_TAP_IDX = 3'h4;
    localparam logic [7:0] RESULT_RST = 8'h00;
    localparam logic [7:0] RESULT_START = 8'h80;
    localparam logic [3:0] DECISIONS_FULL = 4'h8;
    localparam logic [3:0] DECISIONS_RST = 4'h0;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_TRIAL,
        ST_DONE
    } sar_state_e;

    typedef struct packed {
        logic startConvert;
        logic compare;
        logic shortenFeed;
        logic masterClear;
    } sar_in_s;

    typedef struct packed {
        logic [7:0] result;
        logic serial;
        logic eoc;
    } sar_out_s;
endpackage : sar_pkg

// [hw/successive_approx_register.sv]
// Eight-bit successive approximation register with serial and parallel result
`timescale 1ns/1ns

module successive_approx_register #(
    // 1: master-clear variant (cascade slave), 0: shorten-feed variant
    parameter bit CASCADE_SLAVE = 1'b0
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire sar_pkg::sar_in_s ctrlIn,
    output sar_pkg::sar_out_s resultOut
);
    import sar_pkg::*;

    // All inputs are expected synchronous to ref_clk: the start input is
    // often our own end flag looped back, and a synchroniser would break the
    // next-edge restart and the one-decision-per-clock comparator timing.
    sar_state_e state_ff;
    sar_state_e nxt_state;
    logic [2:0] bitIdx_ff;
    logic [2:0] nxt_bitIdx;
    logic [3:0] decisions_ff;
    logic [3:0] nxt_decisions;
    logic startPrev_ff;
    logic clearPrev_ff;
    sar_out_s out_ff;
    sar_out_s nxt_out;
    logic clearActive;
    logic shortenActive;
    logic startEvent;

    assign clearActive = CASCADE_SLAVE && ctrlIn.masterClear;
    assign shortenActive = !CASCADE_SLAVE && ctrlIn.shortenFeed;

    // Rising start, start right after a clear, or recirculation from done.
    // Only the shorten-feed variant recirculates on a held start.
    always_comb begin
        startEvent = ctrlIn.startConvert && (!startPrev_ff ||
            (CASCADE_SLAVE && clearPrev_ff) ||
            (!CASCADE_SLAVE && state_ff == ST_DONE));
    end

    always_comb begin
        nxt_state = state_ff;
        nxt_bitIdx = bitIdx_ff;
        nxt_decisions = decisions_ff;
        nxt_out = out_ff;
        nxt_out.serial = 1'b0;
        if (clearActive) begin
            nxt_state = ST_IDLE;
            nxt_bitIdx = MSB_IDX;
            nxt_decisions = DECISIONS_RST;
            nxt_out.result = RESULT_RST;
            nxt_out.eoc = 1'b0;
        end else if (startEvent) begin
            // Initial period: MSB on trial, serial stays silent
            nxt_state = ST_TRIAL;
            nxt_bitIdx = MSB_IDX;
            nxt_decisions = DECISIONS_RST;
            nxt_out.result = RESULT_START;
            nxt_out.eoc = 1'b0;
        end else begin
            case (state_ff)
                ST_TRIAL: begin
                    nxt_out.result[bitIdx_ff] = ctrlIn.compare;
                    nxt_out.serial = ctrlIn.compare;
                    nxt_decisions = decisions_ff + 4'h1;
                    if (bitIdx_ff == LSB_IDX || shortenActive) begin
                        // Bits below the shorten point stay at zero from the start load
                        // and are to be disregarded by the user.
                        nxt_state = ST_DONE;
                        nxt_out.eoc = 1'b1;
                    end else begin
                        nxt_bitIdx = bitIdx_ff - 3'h1;
                        nxt_out.result[bitIdx_ff - 3'h1] = 1'b1;
                    end
                end
                ST_DONE: begin
                    nxt_out.eoc = 1'b1;
                end
                default: begin
                    nxt_out.eoc = 1'b0;
                end
            endcase
        end
    end

    // Shorten-feed variant leaves reset in done with the end flag high, so a
    // looped-back end flag restarts it at once and it cannot lock up.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_ff <= CASCADE_SLAVE ? ST_IDLE : ST_DONE;
            bitIdx_ff <= MSB_IDX;
            decisions_ff <= DECISIONS_RST;
            startPrev_ff <= 1'b0;
            clearPrev_ff <= 1'b0;
            out_ff.result <= RESULT_RST;
            out_ff.serial <= 1'b0;
            out_ff.eoc <= !CASCADE_SLAVE;
        end else begin
            state_ff <= nxt_state;
            bitIdx_ff <= nxt_bitIdx;
            decisions_ff <= nxt_decisions;
            startPrev_ff <= ctrlIn.startConvert;
            clearPrev_ff <= ctrlIn.masterClear;
            out_ff <= nxt_out;
        end
    end

    assign resultOut = out_ff;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    a_start_trial: assert property (
        startEvent && !clearActive |=>
            state_ff == ST_TRIAL && out_ff.result == RESULT_START
            && !out_ff.eoc)
    else $error("start did not load MSB trial");

    a_serial_init: assert property (
        startEvent || clearActive |=> !out_ff.serial)
    else $error("serial active in initial or reset period");

    a_serial_after_end: assert property (
        $rose(out_ff.eoc) |=> !out_ff.serial)
    else $error("serial active second cycle after end");

    a_serial_matches: assert property (
        state_ff == ST_TRIAL && !startEvent && !clearActive |=>
            out_ff.serial == $past(ctrlIn.compare)
            && out_ff.result[$past(bitIdx_ff)] == $past(ctrlIn.compare))
    else $error("serial bit differs from parallel decision");

    a_msb_first: assert property (
        state_ff == ST_TRIAL && !startEvent && !clearActive
        && bitIdx_ff != LSB_IDX && !shortenActive |=>
            bitIdx_ff == $past(bitIdx_ff) - 3'h1
            && out_ff.result[bitIdx_ff] && state_ff == ST_TRIAL)
    else $error("trial order broken");

    a_full_word: assert property (
        $rose(out_ff.eoc) && !$past(shortenActive) |->
            decisions_ff == DECISIONS_FULL)
    else $error("end flag without eight decisions");

    a_shorten_end: assert property (
        state_ff == ST_TRIAL && shortenActive && !startEvent
        && !clearActive |=> out_ff.eoc ##1 !out_ff.serial)
    else $error("shorten did not end conversion");

    a_recirculate: assert property (
        !CASCADE_SLAVE && out_ff.eoc && ctrlIn.startConvert |=>
            state_ff == ST_TRIAL && !out_ff.eoc)
    else $error("no restart from held start at end");

    a_result_hold: assert property (
        state_ff == ST_DONE && !startEvent && !clearActive |=>
            $stable(out_ff.result) && out_ff.eoc)
    else $error("result changed while end flag high");

    a_master_clear: assert property (
        clearActive |=> out_ff.result == RESULT_RST && !out_ff.eoc
            && !out_ff.serial && state_ff == ST_IDLE)
    else $error("master clear did not zero outputs");

    a_slave_waits: assert property (
        CASCADE_SLAVE && state_ff == ST_IDLE && !ctrlIn.startConvert
        |=> state_ff == ST_IDLE && !out_ff.eoc)
    else $error("cascade slave left reset without start");

    // Serial output only carries decisions made during a trial
    a_serial_idle: assert property (
        state_ff != ST_TRIAL |=> !out_ff.serial)
    else $error("serial active outside a trial");

    a_eoc_in_done: assert property (
        out_ff.eoc |-> state_ff == ST_DONE)
    else $error("end flag high outside done");

    a_shorten_ignored: assert property (
        CASCADE_SLAVE && state_ff == ST_TRIAL && bitIdx_ff != LSB_IDX
        && !startEvent && !clearActive |=> state_ff == ST_TRIAL)
    else $error("slave ended early on shorten input");

    // A held start must not restart the slave, or a cascade would rerun
    a_slave_no_recirc: assert property (
        CASCADE_SLAVE && state_ff == ST_DONE && startPrev_ff
        && !clearPrev_ff && !clearActive |=> state_ff == ST_DONE)
    else $error("slave restarted on held start");

    a_restart_clears: assert property (
        startEvent && !clearActive |=>
            bitIdx_ff == MSB_IDX && decisions_ff == DECISIONS_RST)
    else $error("restart did not reload trial state");

    a_clear_then_start: assert property (
        CASCADE_SLAVE && clearPrev_ff && ctrlIn.startConvert
        && !clearActive |-> startEvent)
    else $error("start after clear not taken");
endmodule : successive_approx_register

// [verification/sar_comparator_model.sv]
// Ideal DAC plus comparator facing the approximation register
`timescale 1ns/1ns
module sar_comparator_model (
    input wire logic [7:0] trial,
    input wire logic [7:0] level,
    output logic keep
);
    // Trial code is kept while it does not exceed the sampled level
    assign keep = (trial <= level);
endmodule : sar_comparator_model

// [verification/successive_approx_register_test.sv]
// Self-checking bench for the successive approximation register
`timescale 1ns/1ns
`define CHK(got, exp) begin nTests++; if ((got) !== (exp)) begin \
    badCount++; $display("[FAIL] %0t got %h exp %h", $time, got, exp); end end
module successive_approx_register_test;
    import sar_pkg::*;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic sc = 1'b0, ff = 1'b0, sc2 = 1'b0, mc2 = 1'b0;
    logic loopEoc = 1'b0, shortMode = 1'b0;
    logic [7:0] level = 8'h00;
    logic keepA, keepB;
    int badCount = 0, nTests = 0, cycles = 0;
    sar_in_s inA, inB;
    sar_out_s outA, outB;
    always #2 ref_clk = ~ref_clk;
    assign inA = {sc, keepA, ff, 1'b0};
    assign inB = {sc2, keepB, 1'b0, mc2};
    sar_comparator_model cmpA_u (.trial(outA.result), .level(level),
        .keep(keepA));
    sar_comparator_model cmpB_u (.trial(outB.result), .level(level),
        .keep(keepB));
    successive_approx_register #(.CASCADE_SLAVE(1'b0)) dut_u (
        .ref_clk(ref_clk), .rst(rst), .ctrlIn(inA), .resultOut(outA));
    successive_approx_register #(.CASCADE_SLAVE(1'b1)) slave_u (
        .ref_clk(ref_clk), .rst(rst), .ctrlIn(inB), .resultOut(outB));
    // External wiring: end flag looped to start, result bit one to shorten
    always @(negedge ref_clk) begin
        if (loopEoc) sc <= outA.eoc;
        ff <= shortMode & outA.result[1];
    end
    task automatic report_and_stop();
        if (badCount == 0 && nTests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : report_and_stop
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            badCount++;
            report_and_stop();
        end
    end
    task automatic run_one(input logic [7:0] tgt);
        level = tgt;
        @(negedge ref_clk) sc = 1'b1;
        @(negedge ref_clk) sc = 1'b0;
        `CHK(outA.result, RESULT_START)
        `CHK(outA.serial, 1'b0)
        for (int k = 7; k >= 0; k--) begin
            @(negedge ref_clk);
            `CHK(outA.serial, tgt[k])
            `CHK(outA.eoc, k == 0)
        end
        `CHK(outA.result, tgt)
        @(negedge ref_clk);
        `CHK(outA.serial, 1'b0)
        `CHK(outA.result, tgt)
    endtask : run_one
    task automatic run_short(input logic [7:0] tgt);
        level = tgt;
        @(negedge ref_clk) sc = 1'b1;
        @(negedge ref_clk) sc = 1'b0;
        shortMode = 1'b1;
        repeat (5) @(negedge ref_clk);
        `CHK(outA.eoc, 1'b0)
        repeat (2) @(negedge ref_clk);
        `CHK(outA.eoc, 1'b1)
        `CHK(outA.result[7:2], tgt[7:2])
        shortMode = 1'b0;
        @(negedge ref_clk);
    endtask : run_short
    task automatic run_loop();
        level = 8'h3C;
        // Nonblocking so the loopback process sees it from the next edge
        @(negedge ref_clk) loopEoc <= 1'b1;
        for (int n = 0; n < 28; n++) begin
            @(negedge ref_clk);
            `CHK(outA.eoc, n % 9 == 0)
        end
        `CHK(outA.result, 8'h3C)
        @(negedge ref_clk) loopEoc <= 1'b0;
        @(negedge ref_clk) sc = 1'b0;
    endtask : run_loop
    task automatic run_slave();
        level = 8'h96;
        @(negedge ref_clk) sc2 = 1'b1;
        repeat (9) @(negedge ref_clk);
        `CHK(outB.eoc, 1'b1)
        repeat (4) @(negedge ref_clk);
        `CHK(outB.eoc, 1'b1)
        `CHK(outB.result, 8'h96)
        mc2 = 1'b1;
        sc2 = 1'b0;
        @(negedge ref_clk) mc2 = 1'b0;
        `CHK(outB.eoc, 1'b0)
        repeat (3) @(negedge ref_clk);
        `CHK(outB.result, RESULT_RST)
        @(negedge ref_clk) sc2 = 1'b1;
        @(negedge ref_clk);
        `CHK(outB.result, RESULT_START)
        @(negedge ref_clk) mc2 = 1'b1;
        @(negedge ref_clk) mc2 = 1'b0;
        `CHK(outB.result, RESULT_RST)
        `CHK(outB.serial, 1'b0)
        @(negedge ref_clk);
        `CHK(outB.result, RESULT_START)
        sc2 = 1'b0;
    endtask : run_slave
    initial begin
        repeat (6) @(negedge ref_clk);
        `CHK(outA.eoc, 1'b1)
        `CHK(outB.eoc, 1'b0)
        `CHK(outA.result, RESULT_RST)
        rst = 1'b0;
        run_one(8'hA5);
        run_one(8'hFF);
        run_one(8'h00);
        run_short(8'h6B);
        run_loop();
        run_one(8'h5A);
        run_slave();
        report_and_stop();
    end
endmodule : successive_approx_register_test
